// ===== rtl/dcei_cfg.svh
// register offsets, field positions and reset values of the dual comparator block
`ifndef DCEI_CFG_SVH
`define DCEI_CFG_SVH

// register indices on the plain register port
`define DCEI_OFS_CN0      8'h00
`define DCEI_OFS_MD0      8'h01
`define DCEI_OFS_CN1      8'h02
`define DCEI_OFS_MD1      8'h03

// control register fields
`define DCEI_CN_EN_BIT    7
`define DCEI_CN_OUT_BIT   6
`define DCEI_CN_RISE_BIT  5
`define DCEI_CN_FALL_BIT  4
`define DCEI_CN_HYP_HI    3
`define DCEI_CN_HYP_LO    2
`define DCEI_CN_HYN_HI    1
`define DCEI_CN_HYN_LO    0

// mode register fields
`define DCEI_MD_RSVD_BIT  7
`define DCEI_MD_RIE_BIT   5
`define DCEI_MD_FIE_BIT   4
`define DCEI_MD_MODE_HI   1
`define DCEI_MD_MODE_LO   0

// reset values
`define DCEI_RST_EN       1'h0
`define DCEI_RST_HYST     2'h0
`define DCEI_RST_IE       1'h0
`define DCEI_RST_MODE     2'h2
`define DCEI_RST_FLAG     1'h0
`define DCEI_RST_RDATA    8'h00
`define DCEI_MD_RSVD_VAL  1'h1
`define DCEI_RST_SHUTDOWN 1'h1
`define DCEI_RST_IRQ      1'h0
`define DCEI_RST_SYNC     1'h0

`endif

// ===== rtl/dcei_pkg.sv
// types of the dual comparator block
package dcei_pkg;

  // which register an address selects
  typedef enum logic [2:0] {
    DCEI_SEL_NONE,
    DCEI_SEL_CN0,
    DCEI_SEL_MD0,
    DCEI_SEL_CN1,
    DCEI_SEL_MD1
  } dcei_sel_e;

  typedef logic [1:0] dcei_hyst_t;
  typedef logic [1:0] dcei_mode_t;
  typedef logic [7:0] dcei_byte_t;

endpackage

// ===== rtl/dcei_channel.sv
// one comparator channel: clock-domain capture, edge detection and sticky edge flags
`timescale 1ns/10ps
`default_nettype none
`include "dcei_cfg.svh"

module dcei_channel (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // gated asynchronous comparator decision
  input  wire logic raw_in,
  // software write of the flag bits
  input  wire logic wr_flags,
  input  wire logic wdata_rise,
  input  wire logic wdata_fall,
  // state seen by software and interrupt logic
  output var  logic status,
  output var  logic rise_flag,
  output var  logic fall_flag
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic sync_a;
  logic prev;
  logic next_sync_a;
  logic next_status;
  logic next_prev;
  logic next_rise_flag;
  logic next_fall_flag;
  logic rise_evt;
  logic fall_evt;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_sync_a = raw_in;
    next_status = sync_a;
    next_prev   = status;
    rise_evt    = status & ~prev;
    fall_evt    = ~status & prev;
    next_rise_flag = rise_flag;
    next_fall_flag = fall_flag;
    // only software changes a flag besides a detected edge
    if (wr_flags) begin
      next_rise_flag = wdata_rise;
      next_fall_flag = wdata_fall;
    end
    // an edge wins over a clear in the same cycle
    if (rise_evt) begin
      next_rise_flag = 1'b1;
    end
    if (fall_evt) begin
      next_fall_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a    <= `DCEI_RST_SYNC;
      status    <= `DCEI_RST_SYNC;
      prev      <= `DCEI_RST_SYNC;
      rise_flag <= `DCEI_RST_FLAG;
      fall_flag <= `DCEI_RST_FLAG;
    end else begin
      sync_a    <= next_sync_a;
      status    <= next_status;
      prev      <= next_prev;
      rise_flag <= next_rise_flag;
      fall_flag <= next_fall_flag;
    end
  end

endmodule // dcei_channel

`default_nettype wire

// ===== rtl/dcei_top.sv
// dual comparator digital side: registers, output gating, edge flags and interrupt requests
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "dcei_cfg.svh"

module dcei_top (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  // analog core decisions, hysteresis already applied
  input  wire logic       CMP_ZERO_ANALOG,
  input  wire logic       CMP_ONE_ANALOG,
  // interrupt controller enables
  input  wire logic       CMP_ZERO_IRQ_SRC_EN,
  input  wire logic       CMP_ONE_IRQ_SRC_EN,
  input  wire logic       GLOBAL_IRQ_EN,
  // comparator zero outputs
  output var  logic       CMP_ZERO_RAW_OUT,
  output var  logic       CMP_ZERO_LATCHED_OUT,
  output var  logic       CMP_ZERO_IRQ,
  output var  logic       CMP_ZERO_SHUTDOWN,
  output var  logic [1:0] CMP_ZERO_RESP_MODE,
  output var  logic [1:0] CMP_ZERO_POS_HYST,
  output var  logic [1:0] CMP_ZERO_NEG_HYST,
  // comparator one outputs
  output var  logic       CMP_ONE_RAW_OUT,
  output var  logic       CMP_ONE_LATCHED_OUT,
  output var  logic       CMP_ONE_IRQ,
  output var  logic       CMP_ONE_SHUTDOWN,
  output var  logic [1:0] CMP_ONE_RESP_MODE,
  output var  logic [1:0] CMP_ONE_POS_HYST,
  output var  logic [1:0] CMP_ONE_NEG_HYST
);

  localparam int NCMP = 2;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // unmapped indices select nothing: writes drop, reads give zero
  function automatic dcei_pkg::dcei_sel_e decode(input logic [7:0] a);
    dcei_pkg::dcei_sel_e s;
    s = dcei_pkg::DCEI_SEL_NONE;
    if (a == `DCEI_OFS_CN0) begin
      s = dcei_pkg::DCEI_SEL_CN0;
    end else if (a == `DCEI_OFS_MD0) begin
      s = dcei_pkg::DCEI_SEL_MD0;
    end else if (a == `DCEI_OFS_CN1) begin
      s = dcei_pkg::DCEI_SEL_CN1;
    end else if (a == `DCEI_OFS_MD1) begin
      s = dcei_pkg::DCEI_SEL_MD1;
    end
    return s;
  endfunction

  // strobes qualify the decoded index
  dcei_pkg::dcei_sel_e sel_wr;
  dcei_pkg::dcei_sel_e sel_rd;

  assign sel_wr = WR ? decode(ADDR) : dcei_pkg::DCEI_SEL_NONE;
  assign sel_rd = RD ? decode(ADDR) : dcei_pkg::DCEI_SEL_NONE;

  // ----------------------------------------
  // per-comparator signals
  // ----------------------------------------
  // one array element per comparator
  logic                   analog    [NCMP];
  logic                   src_en    [NCMP];
  logic                   en        [NCMP];
  dcei_pkg::dcei_hyst_t   hyp       [NCMP];
  dcei_pkg::dcei_hyst_t   hyn       [NCMP];
  logic                   rie       [NCMP];
  logic                   fie       [NCMP];
  dcei_pkg::dcei_mode_t   mode      [NCMP];
  logic                   raw       [NCMP];
  logic                   status    [NCMP];
  logic                   rise_flag [NCMP];
  logic                   fall_flag [NCMP];
  logic                   irq       [NCMP];
  logic                   shutdown  [NCMP];
  logic                   wr_cn     [NCMP];
  logic                   wr_md     [NCMP];

  assign analog[0] = CMP_ZERO_ANALOG;
  assign analog[1] = CMP_ONE_ANALOG;
  assign src_en[0] = CMP_ZERO_IRQ_SRC_EN;
  assign src_en[1] = CMP_ONE_IRQ_SRC_EN;

  assign wr_cn[0] = (sel_wr == dcei_pkg::DCEI_SEL_CN0);
  assign wr_md[0] = (sel_wr == dcei_pkg::DCEI_SEL_MD0);
  assign wr_cn[1] = (sel_wr == dcei_pkg::DCEI_SEL_CN1);
  assign wr_md[1] = (sel_wr == dcei_pkg::DCEI_SEL_MD1);

  // ----------------------------------------
  // comparator channels
  // ----------------------------------------
  // both channels are built from one description
  for (genvar i = 0; i < NCMP; i++) begin : g_cmp

    logic                 next_en;
    dcei_pkg::dcei_hyst_t next_hyp;
    dcei_pkg::dcei_hyst_t next_hyn;
    logic                 next_rie;
    logic                 next_fie;
    dcei_pkg::dcei_mode_t next_mode;
    logic                 next_irq;
    logic                 next_shutdown;

    // asynchronous path, valid with the clock stopped
    assign raw[i] = en[i] & analog[i];

    dcei_channel u_chan (
      .clk        (CLK),
      .arst_n     (ARST_N),
      .raw_in     (raw[i]),
      .wr_flags   (wr_cn[i]),
      .wdata_rise (WDATA[`DCEI_CN_RISE_BIT]),
      .wdata_fall (WDATA[`DCEI_CN_FALL_BIT]),
      .status     (status[i]),
      .rise_flag  (rise_flag[i]),
      .fall_flag  (fall_flag[i])
    );

    // settings follow register writes
    always_comb begin
      next_en   = en[i];
      next_hyp  = hyp[i];
      next_hyn  = hyn[i];
      next_rie  = rie[i];
      next_fie  = fie[i];
      next_mode = mode[i];
      // output state bit is read-only
      if (wr_cn[i]) begin
        next_en  = WDATA[`DCEI_CN_EN_BIT];
        next_hyp = WDATA[`DCEI_CN_HYP_HI:`DCEI_CN_HYP_LO];
        next_hyn = WDATA[`DCEI_CN_HYN_HI:`DCEI_CN_HYN_LO];
      end
      // reserved and unused mode bits are dropped
      if (wr_md[i]) begin
        next_rie  = WDATA[`DCEI_MD_RIE_BIT];
        next_fie  = WDATA[`DCEI_MD_FIE_BIT];
        next_mode = WDATA[`DCEI_MD_MODE_HI:`DCEI_MD_MODE_LO];
      end
      // shutdown follows the stored enable
      next_shutdown = ~next_en;
      // request level follows the sticky flags
      next_irq = src_en[i] & GLOBAL_IRQ_EN &
                 ((rise_flag[i] & rie[i]) | (fall_flag[i] & fie[i]));
    end

    // settings, shutdown and request registers
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        en[i]       <= `DCEI_RST_EN;
        hyp[i]      <= `DCEI_RST_HYST;
        hyn[i]      <= `DCEI_RST_HYST;
        rie[i]      <= `DCEI_RST_IE;
        fie[i]      <= `DCEI_RST_IE;
        mode[i]     <= `DCEI_RST_MODE;
        shutdown[i] <= `DCEI_RST_SHUTDOWN;
        irq[i]      <= `DCEI_RST_IRQ;
      end else begin
        en[i]       <= next_en;
        hyp[i]      <= next_hyp;
        hyn[i]      <= next_hyn;
        rie[i]      <= next_rie;
        fie[i]      <= next_fie;
        mode[i]     <= next_mode;
        shutdown[i] <= next_shutdown;
        irq[i]      <= next_irq;
      end
    end

  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  dcei_pkg::dcei_byte_t next_rdata;

  // register images as software reads them
  function automatic dcei_pkg::dcei_byte_t cn_word(
    input logic                 e,
    input logic                 o,
    input logic                 r,
    input logic                 f,
    input dcei_pkg::dcei_hyst_t p,
    input dcei_pkg::dcei_hyst_t n
  );
    dcei_pkg::dcei_byte_t w;
    w = 8'h00;
    w[`DCEI_CN_EN_BIT]   = e;
    w[`DCEI_CN_OUT_BIT]  = o;
    w[`DCEI_CN_RISE_BIT] = r;
    w[`DCEI_CN_FALL_BIT] = f;
    w[`DCEI_CN_HYP_HI:`DCEI_CN_HYP_LO] = p;
    w[`DCEI_CN_HYN_HI:`DCEI_CN_HYN_LO] = n;
    return w;
  endfunction

  function automatic dcei_pkg::dcei_byte_t md_word(
    input logic                 r,
    input logic                 f,
    input dcei_pkg::dcei_mode_t m
  );
    dcei_pkg::dcei_byte_t w;
    w = 8'h00;
    // reserved bit always reads one
    w[`DCEI_MD_RSVD_BIT] = `DCEI_MD_RSVD_VAL;
    w[`DCEI_MD_RIE_BIT]  = r;
    w[`DCEI_MD_FIE_BIT]  = f;
    w[`DCEI_MD_MODE_HI:`DCEI_MD_MODE_LO] = m;
    return w;
  endfunction

  always_comb begin
    next_rdata = `DCEI_RST_RDATA;
    unique case (sel_rd)
      dcei_pkg::DCEI_SEL_NONE: begin
        next_rdata = `DCEI_RST_RDATA;
      end
      dcei_pkg::DCEI_SEL_CN0: begin
        next_rdata = cn_word(en[0], status[0], rise_flag[0], fall_flag[0],
                             hyp[0], hyn[0]);
      end
      dcei_pkg::DCEI_SEL_MD0: begin
        next_rdata = md_word(rie[0], fie[0], mode[0]);
      end
      dcei_pkg::DCEI_SEL_CN1: begin
        next_rdata = cn_word(en[1], status[1], rise_flag[1], fall_flag[1],
                             hyp[1], hyn[1]);
      end
      dcei_pkg::DCEI_SEL_MD1: begin
        next_rdata = md_word(rie[1], fie[1], mode[1]);
      end
      default: begin
        next_rdata = `DCEI_RST_RDATA;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= `DCEI_RST_RDATA;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // output ports
  // ----------------------------------------
  // raw outputs bypass the clock so wake-up works without it
  // every other output comes straight from a register
  assign CMP_ZERO_RAW_OUT     = raw[0];
  assign CMP_ZERO_LATCHED_OUT = status[0];
  assign CMP_ZERO_IRQ         = irq[0];
  assign CMP_ZERO_SHUTDOWN    = shutdown[0];
  assign CMP_ZERO_RESP_MODE   = mode[0];
  assign CMP_ZERO_POS_HYST    = hyp[0];
  assign CMP_ZERO_NEG_HYST    = hyn[0];

  assign CMP_ONE_RAW_OUT      = raw[1];
  assign CMP_ONE_LATCHED_OUT  = status[1];
  assign CMP_ONE_IRQ          = irq[1];
  assign CMP_ONE_SHUTDOWN     = shutdown[1];
  assign CMP_ONE_RESP_MODE    = mode[1];
  assign CMP_ONE_POS_HYST     = hyp[1];
  assign CMP_ONE_NEG_HYST     = hyn[1];

endmodule // dcei_top

`default_nettype wire

// ===== verif/dcei_top_properties.sv
// concurrent checks on the ports of the dual comparator top
`timescale 1ns/10ps
`default_nettype none
`include "dcei_cfg.svh"

module dcei_top_properties (
  // clock and reset
  input wire logic       CLK,
  input wire logic       ARST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // comparator zero
  input wire logic       CMP_ZERO_ANALOG,
  input wire logic       CMP_ZERO_IRQ_SRC_EN,
  input wire logic       GLOBAL_IRQ_EN,
  input wire logic       CMP_ZERO_RAW_OUT,
  input wire logic       CMP_ZERO_LATCHED_OUT,
  input wire logic       CMP_ZERO_IRQ,
  input wire logic       CMP_ZERO_SHUTDOWN,
  input wire logic [1:0] CMP_ZERO_RESP_MODE,
  // comparator one
  input wire logic [1:0] CMP_ONE_POS_HYST,
  input wire logic [1:0] CMP_ONE_NEG_HYST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_raw_forced_low: assert property (CMP_ZERO_SHUTDOWN |-> !CMP_ZERO_RAW_OUT)
    else $error("raw output high while shut down");
  a_raw_follows_core: assert property (!CMP_ZERO_SHUTDOWN |->
    CMP_ZERO_RAW_OUT == CMP_ZERO_ANALOG)
    else $error("raw output differs from core decision");
  a_latched_two_edges: assert property (
    CMP_ZERO_LATCHED_OUT == $past(CMP_ZERO_RAW_OUT, 2))
    else $error("latched output not raw delayed by two edges");
  a_irq_needs_enables: assert property (CMP_ZERO_IRQ |->
    $past(GLOBAL_IRQ_EN) && $past(CMP_ZERO_IRQ_SRC_EN))
    else $error("request without source and global enable");
  a_irq_global_drop: assert property ($fell(GLOBAL_IRQ_EN) |=> !CMP_ZERO_IRQ)
    else $error("request stays after global disable");
  a_irq_flag_holds: assert property (CMP_ZERO_IRQ && GLOBAL_IRQ_EN
    && CMP_ZERO_IRQ_SRC_EN && !WR && !$past(WR) |=> CMP_ZERO_IRQ)
    else $error("request dropped without software action");
  a_enable_shutdown: assert property (WR && ADDR == `DCEI_OFS_CN0 |=>
    CMP_ZERO_SHUTDOWN == !$past(WDATA[`DCEI_CN_EN_BIT]))
    else $error("shutdown does not follow enable write");
  a_mode_write: assert property (WR && ADDR == `DCEI_OFS_MD0 |=>
    CMP_ZERO_RESP_MODE == $past(WDATA[1:0]))
    else $error("response mode does not follow write");
  a_hyst_write: assert property (WR && ADDR == `DCEI_OFS_CN1 |=>
    {CMP_ONE_POS_HYST, CMP_ONE_NEG_HYST} == $past(WDATA[3:0]))
    else $error("hysteresis codes do not follow write");
  a_rd_status_bit: assert property (RD && ADDR == `DCEI_OFS_CN0 |=>
    RDATA[`DCEI_CN_OUT_BIT] == $past(CMP_ZERO_LATCHED_OUT)
    && RDATA[`DCEI_CN_EN_BIT] == !$past(CMP_ZERO_SHUTDOWN))
    else $error("control read shows wrong output or enable");
  a_rd_mode_image: assert property (RD && ADDR == `DCEI_OFS_MD0 |=>
    RDATA[`DCEI_MD_RSVD_BIT] && RDATA[1:0] == $past(CMP_ZERO_RESP_MODE))
    else $error("mode read shows wrong reserved bit or mode");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside the read answer cycle");
endmodule // dcei_top_properties

bind dcei_top dcei_top_properties u_props (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_ZERO_ANALOG(CMP_ZERO_ANALOG),
  .CMP_ZERO_IRQ_SRC_EN(CMP_ZERO_IRQ_SRC_EN), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
  .CMP_ZERO_RAW_OUT(CMP_ZERO_RAW_OUT), .CMP_ZERO_LATCHED_OUT(CMP_ZERO_LATCHED_OUT),
  .CMP_ZERO_IRQ(CMP_ZERO_IRQ), .CMP_ZERO_SHUTDOWN(CMP_ZERO_SHUTDOWN),
  .CMP_ZERO_RESP_MODE(CMP_ZERO_RESP_MODE), .CMP_ONE_POS_HYST(CMP_ONE_POS_HYST),
  .CMP_ONE_NEG_HYST(CMP_ONE_NEG_HYST));
`default_nettype wire

// ===== verif/dcei_analog_model.sv
// behavioural analog comparator core with programmable hysteresis
`timescale 1ns/10ps
`default_nettype none

module dcei_analog_model (
  // settings from the digital side
  input  wire logic       shutdown,
  input  wire logic [1:0] pos_hyst,
  input  wire logic [1:0] neg_hyst,
  // input voltages in millivolts
  input  var  int         vp_mv,
  input  var  int         vn_mv,
  // decision
  output var  logic       decision
);
  function automatic int amount(input logic [1:0] code);
    case (code)
      2'h1: return 5;
      2'h2: return 10;
      2'h3: return 20;
      default: return 0;
    endcase
  endfunction

  initial decision = 1'b0;
  always @(shutdown or pos_hyst or neg_hyst or vp_mv or vn_mv) begin
    if (shutdown) begin
      decision = 1'b0;
    end else if (!decision && vp_mv - vn_mv >= ((pos_hyst == 2'h0) ? 1 : amount(pos_hyst))) begin
      decision = 1'b1;
    end else if (decision && vn_mv - vp_mv >= amount(neg_hyst)) begin
      decision = 1'b0;
    end
  end
endmodule // dcei_analog_model
`default_nettype wire

// ===== verif/test_dual_comparator_edge_irq.sv
// self-checking bench of the dual comparator block
`timescale 1ns/10ps
`default_nettype none
`include "dcei_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module test_dual_comparator_edge_irq;
  logic       clk, arst_n, wr, rd, src0, src1, gie;
  logic [7:0] addr, wdata, rdata, d;
  wire logic  ana0, ana1;
  logic       raw0, lat0, irq0, shd0, raw1, lat1, irq1, shd1;
  logic [1:0] mode0, ph0, nh0, mode1, ph1, nh1;
  int         vp [2], vn [2], checks, fail_count, c;
  int         mv [4] = '{0, 5, 10, 20};

  dcei_top uut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CMP_ZERO_ANALOG(ana0), .CMP_ONE_ANALOG(ana1), .CMP_ZERO_IRQ_SRC_EN(src0),
    .CMP_ONE_IRQ_SRC_EN(src1), .GLOBAL_IRQ_EN(gie), .CMP_ZERO_RAW_OUT(raw0),
    .CMP_ZERO_LATCHED_OUT(lat0), .CMP_ZERO_IRQ(irq0), .CMP_ZERO_SHUTDOWN(shd0),
    .CMP_ZERO_RESP_MODE(mode0), .CMP_ZERO_POS_HYST(ph0), .CMP_ZERO_NEG_HYST(nh0),
    .CMP_ONE_RAW_OUT(raw1), .CMP_ONE_LATCHED_OUT(lat1), .CMP_ONE_IRQ(irq1),
    .CMP_ONE_SHUTDOWN(shd1), .CMP_ONE_RESP_MODE(mode1), .CMP_ONE_POS_HYST(ph1),
    .CMP_ONE_NEG_HYST(nh1));
  dcei_analog_model u_core0 (.shutdown(shd0), .pos_hyst(ph0), .neg_hyst(nh0),
    .vp_mv(vp[0]), .vn_mv(vn[0]), .decision(ana0));
  dcei_analog_model u_core1 (.shutdown(shd1), .pos_hyst(ph1), .neg_hyst(nh1),
    .vp_mv(vp[1]), .vn_mv(vn[1]), .decision(ana1));

  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
  // input voltage change, raw checked at once, latched checked after three edges
  task automatic step(input int ch, input int v, input logic e);
    @(posedge clk);
    vp[ch] <= v;
    @(negedge clk);
    `CHK(ch ? raw1 : raw0, e)
    wait_cyc(3);
    `CHK(ch ? lat1 : lat0, e)
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {arst_n, wr, rd, src0, src1, gie, addr, wdata} = '0;
    vp = '{0, 0};
    vn = '{1000, 1000};
    checks = 0;
    fail_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (c = 0; c < 5; c++) begin
      reg_rd(c[7:0], d);
      `CHK(d, (c % 2 == 1) ? 8'h82 : 8'h00)
    end
    `CHK({shd0, shd1}, 2'h3)
    for (c = 0; c < 4; c++) begin
      reg_wr(`DCEI_OFS_MD1, 8'hCC | c[7:0]);
      reg_rd(`DCEI_OFS_MD1, d);
      `CHK({d, mode1}, {8'h80 | c[7:0], c[1:0]})
    end
    for (c = 0; c < 4; c++) begin
      reg_wr(`DCEI_OFS_CN1, 8'h80 | c[7:0] << 2 | c[7:0]);
      `CHK({ph1, nh1, shd1}, {c[1:0], c[1:0], 1'b0})
      step(1, 1000 + (c ? mv[c] : 1) - 1, 1'b0);
      step(1, 1000 + (c ? mv[c] : 1), 1'b1);
      step(1, 1000 - mv[c] + 1, 1'b1);
      step(1, 1000 - mv[c], 1'b0);
      reg_rd(`DCEI_OFS_CN1, d);
      `CHK(d, 8'hB0 | c[7:0] << 2 | c[7:0])
    end
    reg_wr(`DCEI_OFS_MD0, 8'h80);
    reg_wr(`DCEI_OFS_CN0, 8'h80);
    @(posedge clk);
    src0 <= 1'b1;
    step(0, 1050, 1'b1);
    reg_rd(`DCEI_OFS_CN0, d);
    `CHK({d, irq0}, {8'hE0, 1'b0})
    reg_wr(`DCEI_OFS_MD0, 8'hA0);
    @(posedge clk);
    gie <= 1'b1;
    wait_cyc(3);
    `CHK(irq0, 1'b1)
    wait_cyc(20);
    reg_rd(`DCEI_OFS_CN0, d);
    `CHK({d, irq0}, {8'hE0, 1'b1})
    @(posedge clk);
    src0 <= 1'b0;
    wait_cyc(3);
    `CHK(irq0, 1'b0)
    @(posedge clk);
    src0 <= 1'b1;
    reg_wr(`DCEI_OFS_CN0, 8'h80);
    wait_cyc(3);
    reg_rd(`DCEI_OFS_CN0, d);
    `CHK({d, irq0}, {8'hC0, 1'b0})
    step(0, 950, 1'b0);
    reg_rd(`DCEI_OFS_CN0, d);
    `CHK({d, irq0}, {8'h90, 1'b0})
    reg_wr(`DCEI_OFS_MD0, 8'h91);
    wait_cyc(3);
    `CHK({irq0, mode0}, {1'b1, 2'h1})
    @(posedge clk);
    gie <= 1'b0;
    wait_cyc(3);
    `CHK(irq0, 1'b0)
    step(0, 1050, 1'b1);
    reg_wr(`DCEI_OFS_CN0, 8'h06);
    wait_cyc(3);
    reg_rd(`DCEI_OFS_CN0, d);
    `CHK({d, raw0, lat0, shd0, ph0, nh0}, {8'h16, 3'h1, 2'h1, 2'h2})
    reg_wr(`DCEI_OFS_MD1, 8'hB3);
    @(posedge clk);
    {src1, gie} <= 2'h3;
    wait_cyc(3);
    `CHK({irq0, irq1}, 2'h3)
    reg_wr(`DCEI_OFS_CN1, 8'h8F);
    wait_cyc(3);
    `CHK({irq0, irq1, ph1, nh1}, {2'h2, 2'h3, 2'h3})
    give_verdict();
  end
endmodule // test_dual_comparator_edge_irq
`default_nettype wire
